/* logic/seo_params.svh */
// Register indices, field positions, reset values and timing defaults.
`ifndef SEO_PARAMS_SVH
`define SEO_PARAMS_SVH

// Register indices; the byte address on the bus is four times the index.
`define SEO_IDX_BLANK_SEL   8'h69
`define SEO_IDX_HS_HI       8'h7C
`define SEO_IDX_HS_LO       8'h7D
`define SEO_IDX_VS          8'h7F
`define SEO_IDX_EVEN_VS     8'h89
`define SEO_IDX_DE_HI       8'h8B
`define SEO_IDX_DE_TRAIL_LO 8'h8C
`define SEO_IDX_DE_LEAD_LO  8'h8D
`define SEO_IDX_VBLANK      8'h8E
`define SEO_IDX_CTRL        8'hA0
`define SEO_IDX_STATUS      8'hA1

// Field positions.
`define SEO_BIT_BLANK_SEL   2
`define SEO_BIT_RUN         0
`define SEO_BIT_INTERLACE   1
`define SEO_BIT_MODE_525P   2

// Reset values.
`define SEO_RST_PIX_OFS     10'h000
`define SEO_RST_LINE_OFS    4'h0
`define SEO_RST_CTRL        3'h0

// Line 523 is the compliant blanking start for 525-line progressive.
`define SEO_VB_START_COMPL  523
`define SEO_VB_START_LINE1  1

// Nominal timing defaults, in pixels and lines counted from zero.
`define SEO_H_TOTAL         858
`define SEO_HS_WIDTH        64
`define SEO_DE_BEGIN        116
`define SEO_DE_STOP         836
`define SEO_V_TOTAL         525
`define SEO_VS_START        6
`define SEO_VS_END          12
`define SEO_VB_START        0
`define SEO_VB_END          42
`define SEO_PIX_DIV         1

`endif

/* logic/seo_pkg.sv */
// Types shared by the sync edge offset block.
package seo_pkg;

    typedef struct packed {
        logic [9:0] hs_trail;
        logic [3:0] vs_lead;
        logic [3:0] vs_trail;
        logic [3:0] even_vs_lead;
        logic [3:0] even_vs_trail;
        logic [9:0] de_trail;
        logic [9:0] de_lead;
        logic [3:0] vb_start;
        logic [3:0] vb_end;
        logic       blank_sel;
    } seo_offsets_t;

    typedef struct packed {
        logic hsync;
        logic vsync;
        logic de;
        logic field;
    } seo_sync_t;

endpackage

/* logic/seo_edge_flag.sv */
// Level flag that an edge sets and another edge clears.
`timescale 1ns/100ps

module seo_edge_flag (
    input  wire logic sys_clk,
    input  wire logic nrst,
    input  wire logic en,
    input  wire logic set,
    input  wire logic clr,
    output logic      flag
);

    // A clear on the same position as a set wins, so a zero-width
    // pulse collapses instead of sticking high.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            flag <= 1'b0;
        end else if (en) begin
            if (clr) begin
                flag <= 1'b0;
            end else if (set) begin
                flag <= 1'b1;
            end
        end
    end

endmodule

/* logic/seo_timing.sv */
// Sync and data enable generator with programmable edge offsets.
// Summary of operation
// [R01] Horizontal sync trailing edge moves by a signed 10-bit pixel count.
// [R02] Codes up to 0x1FF delay it; codes from 0x200 advance it.
// [R03] In 525-line progressive, a bit picks blanking start line 1 or 523.
// [R04] Vertical sync leading edge moves by a signed 4-bit line count.
// [R05] Vertical edges move in whole lines, seven later to eight earlier.
// [R06] Vertical sync trailing edge moves by a signed 4-bit line count.
// [R07] Line code 0xF means one line earlier, 0x8 eight lines earlier.
// [R08] Even fields use their own vertical sync leading edge offset.
// [R09] Even fields use their own vertical sync trailing edge offset.
// [R10] Data enable trailing edge moves by a signed 10-bit pixel count.
// [R11] Data enable leading edge moves by its own signed pixel count.
// [R12] Blanking start moves by a signed 4-bit line count.
// [R13] Blanking end moves by a signed 4-bit line count.
// [R14] Zero offset, the reset value, keeps every edge at nominal.
// [R15] Offsets are relative: negative advances, positive delays.
// [R16] Offsets are taken into the generator at a frame boundary, and on every cycle while it is stopped.
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/100ps
`include "seo_params.svh"

module seo_timing #(
    parameter int H_TOTAL    = `SEO_H_TOTAL,
    parameter int HS_WIDTH   = `SEO_HS_WIDTH,
    parameter int DE_BEGIN   = `SEO_DE_BEGIN,
    parameter int DE_STOP    = `SEO_DE_STOP,
    parameter int V_TOTAL    = `SEO_V_TOTAL,
    parameter int VS_START   = `SEO_VS_START,
    parameter int VS_END     = `SEO_VS_END,
    parameter int VB_START   = `SEO_VB_START,
    parameter int VB_END     = `SEO_VB_END,
    parameter int PIX_DIV    = `SEO_PIX_DIV
) (
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [9:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    output seo_pkg::seo_sync_t     sync_out
);

    localparam int CW = 12;

    // Counters are CW bits wide and the divider eight; nominal edges
    // must fall inside the line or frame that they belong to.
    generate
        if (H_TOTAL < 16 || H_TOTAL > 4095) begin : g_bad_h
            $error("seo_timing: H_TOTAL out of range.");
        end
        if (V_TOTAL < 16 || V_TOTAL > 4095) begin : g_bad_v
            $error("seo_timing: V_TOTAL out of range.");
        end
        if (PIX_DIV < 1 || PIX_DIV > 256) begin : g_bad_div
            $error("seo_timing: PIX_DIV out of range.");
        end
        if (HS_WIDTH < 1 || HS_WIDTH >= H_TOTAL) begin : g_bad_hs
            $error("seo_timing: HS_WIDTH out of range.");
        end
        if (DE_BEGIN >= DE_STOP || DE_STOP >= H_TOTAL) begin : g_bad_de
            $error("seo_timing: data enable span out of range.");
        end
        if (VS_START >= V_TOTAL || VS_END >= V_TOTAL) begin : g_bad_vs
            $error("seo_timing: vertical sync lines out of range.");
        end
        if (VB_START >= V_TOTAL || VB_END >= V_TOTAL) begin : g_bad_vb
            $error("seo_timing: blanking lines out of range.");
        end
    endgenerate

    // Adds a signed offset to a nominal position and wraps it into
    // one line or one frame, so moved edges stay on a reachable count.
    // The wrap is applied once: a sum more than one line or frame past either
    // end leaves the edge off the count, and that edge then does not occur.
    function automatic logic [CW-1:0] seo_place(
        input logic [CW-1:0] nominal,
        input logic [9:0]    ofs,
        input logic [CW-1:0] total
    );
        logic signed [CW+1:0] sum;
        sum = $signed({2'b00, nominal}) +
              $signed({{(CW-8){ofs[9]}}, ofs});
        if (sum < 0) begin
            sum = sum + $signed({2'b00, total});
        end else if (sum >= $signed({2'b00, total})) begin
            sum = sum - $signed({2'b00, total});
        end
        return sum[CW-1:0];
    endfunction

    // Widens a 4-bit signed line offset to the pixel offset width.
    function automatic logic [9:0] seo_lines(input logic [3:0] ofs);
        return {{6{ofs[3]}}, ofs};
    endfunction

    localparam logic [CW-1:0] HT   = CW'(H_TOTAL);
    localparam logic [CW-1:0] VT   = CW'(V_TOTAL);
    localparam logic [CW-1:0] HSW  = CW'(HS_WIDTH);
    localparam logic [CW-1:0] DHS  = CW'(DE_BEGIN);
    localparam logic [CW-1:0] DHE  = CW'(DE_STOP);
    localparam logic [CW-1:0] VSS  = CW'(VS_START);
    localparam logic [CW-1:0] VSE  = CW'(VS_END);
    localparam logic [CW-1:0] VBS  = CW'(VB_START);
    localparam logic [CW-1:0] VBE  = CW'(VB_END);
    localparam logic [CW-1:0] VBC  = CW'(`SEO_VB_START_COMPL - 1);
    localparam logic [CW-1:0] VB1  = CW'(`SEO_VB_START_LINE1 - 1);
    localparam logic [7:0]    PDIV = 8'(PIX_DIV - 1);

    // Software copy of the offsets and the control bits.
    seo_pkg::seo_offsets_t ofs;
    seo_pkg::seo_offsets_t shadow;
    logic [2:0]            ctrl;

    // Generator state.
    logic [7:0]    div_cnt;
    logic          pix_en;
    logic [CW-1:0] hcnt;
    logic [CW-1:0] vcnt;
    logic          field;
    logic          hs_flag;
    logic          vs_flag;
    logic          vb_flag;
    logic          hde_flag;

    // Bus decode.
    wire        bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire        bus_wr    = bus_req && wb_we_i && wb_sel_i[0];
    wire [7:0]  bus_idx   = wb_adr_i[9:2];
    wire [7:0]  wbyte     = wb_dat_i[7:0];
    wire        hit_sel   = bus_idx == `SEO_IDX_BLANK_SEL;
    wire        hit_hs_hi = bus_idx == `SEO_IDX_HS_HI;
    wire        hit_hs_lo = bus_idx == `SEO_IDX_HS_LO;
    wire        hit_vs    = bus_idx == `SEO_IDX_VS;
    wire        hit_evs   = bus_idx == `SEO_IDX_EVEN_VS;
    wire        hit_de_hi = bus_idx == `SEO_IDX_DE_HI;
    wire        hit_det   = bus_idx == `SEO_IDX_DE_TRAIL_LO;
    wire        hit_del   = bus_idx == `SEO_IDX_DE_LEAD_LO;
    wire        hit_vb    = bus_idx == `SEO_IDX_VBLANK;
    wire        hit_ctrl  = bus_idx == `SEO_IDX_CTRL;
    wire        hit_stat  = bus_idx == `SEO_IDX_STATUS;

    wire [7:0]  rd_byte =
        hit_sel   ? {5'h0, ofs.blank_sel, 2'h0} :
        hit_hs_hi ? {6'h0, ofs.hs_trail[9:8]} :
        hit_hs_lo ? ofs.hs_trail[7:0] :
        hit_vs    ? {ofs.vs_lead, ofs.vs_trail} :
        hit_evs   ? {ofs.even_vs_lead, ofs.even_vs_trail} :
        hit_de_hi ? {4'h0, ofs.de_lead[9:8], ofs.de_trail[9:8]} :
        hit_det   ? ofs.de_trail[7:0] :
        hit_del   ? ofs.de_lead[7:0] :
        hit_vb    ? {ofs.vb_start, ofs.vb_end} :
        hit_ctrl  ? {5'h0, ctrl} :
        hit_stat  ? {4'h0, hs_flag, vs_flag, vb_flag, field} :
                    8'h00;

    // Classic single cycle: one wait state, ack for one cycle.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    // [R14] Zero reset offsets.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ofs.hs_trail      <= `SEO_RST_PIX_OFS;
            ofs.de_trail      <= `SEO_RST_PIX_OFS;
            ofs.de_lead       <= `SEO_RST_PIX_OFS;
            ofs.vs_lead       <= `SEO_RST_LINE_OFS;
            ofs.vs_trail      <= `SEO_RST_LINE_OFS;
            ofs.even_vs_lead  <= `SEO_RST_LINE_OFS;
            ofs.even_vs_trail <= `SEO_RST_LINE_OFS;
            ofs.vb_start      <= `SEO_RST_LINE_OFS;
            ofs.vb_end        <= `SEO_RST_LINE_OFS;
            ofs.blank_sel     <= 1'b0;
            ctrl              <= `SEO_RST_CTRL;
        end else if (bus_wr) begin
            if (hit_sel) begin
                ofs.blank_sel <= wbyte[`SEO_BIT_BLANK_SEL];
            end
            if (hit_hs_hi) begin
                ofs.hs_trail[9:8] <= wbyte[1:0];
            end
            if (hit_hs_lo) begin
                ofs.hs_trail[7:0] <= wbyte;
            end
            if (hit_vs) begin
                {ofs.vs_lead, ofs.vs_trail} <= wbyte;
            end
            if (hit_evs) begin
                {ofs.even_vs_lead, ofs.even_vs_trail} <= wbyte;
            end
            if (hit_de_hi) begin
                {ofs.de_lead[9:8], ofs.de_trail[9:8]} <= wbyte[3:0];
            end
            if (hit_det) begin
                ofs.de_trail[7:0] <= wbyte;
            end
            if (hit_del) begin
                ofs.de_lead[7:0] <= wbyte;
            end
            if (hit_vb) begin
                {ofs.vb_start, ofs.vb_end} <= wbyte;
            end
            if (hit_ctrl) begin
                ctrl <= wbyte[2:0];
            end
        end
    end

    // Pixel rate enable.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            div_cnt <= 8'h00;
            pix_en  <= 1'b0;
        end else begin
            div_cnt <= (div_cnt == PDIV) ? 8'h00 : div_cnt + 8'h01;
            pix_en  <= (div_cnt == PDIV) && ctrl[`SEO_BIT_RUN];
        end
    end

    wire run        = ctrl[`SEO_BIT_RUN];
    wire line_end   = hcnt == HT - CW'(1);
    wire frame_end  = line_end && (vcnt == VT - CW'(1));
    wire line_start = hcnt == '0;

    // [R16] Frame boundary latch.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            shadow <= '0;
        end else if (!run || (pix_en && frame_end)) begin
            shadow <= ofs;
        end
    end

    // Counters; the field flips per frame only in interlaced mode.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            hcnt  <= '0;
            vcnt  <= '0;
            field <= 1'b0;
        end else if (!run) begin
            hcnt  <= '0;
            vcnt  <= '0;
            field <= 1'b0;
        end else if (pix_en) begin
            hcnt <= line_end ? '0 : hcnt + CW'(1);
            if (line_end) begin
                vcnt <= frame_end ? '0 : vcnt + CW'(1);
            end
            if (frame_end) begin
                field <= ctrl[`SEO_BIT_INTERLACE] && !field;
            end
        end
    end

    wire even = field;

    // [R01] [R02] [R15] Signed pixel shift of the trailing sync edge.
    wire [CW-1:0] hs_end_pos = seo_place(HSW, shadow.hs_trail, HT);

    // [R08] [R09] Even fields select their own vertical offsets.
    wire [3:0] vs_lead_sel  = even ? shadow.even_vs_lead  : shadow.vs_lead;
    wire [3:0] vs_trail_sel = even ? shadow.even_vs_trail : shadow.vs_trail;

    // [R04] [R06] [R07] Sign-extended line shifts of the sync edges.
    wire [CW-1:0] vs_start_pos = seo_place(VSS, seo_lines(vs_lead_sel), VT);
    wire [CW-1:0] vs_end_pos   = seo_place(VSE, seo_lines(vs_trail_sel), VT);

    // [R03] Compliant blanking start for 525-line progressive only.
    wire [CW-1:0] vb_nominal = !ctrl[`SEO_BIT_MODE_525P] ? VBS :
                               shadow.blank_sel ? VBC : VB1;

    // [R12] [R13] Blanking start and end line shifts.
    wire [CW-1:0] vb_start_pos =
        seo_place(vb_nominal, seo_lines(shadow.vb_start), VT);
    wire [CW-1:0] vb_end_pos   =
        seo_place(VBE, seo_lines(shadow.vb_end), VT);

    // [R11] [R10] Pixel shifts of the data enable edges.
    wire [CW-1:0] de_start_pos = seo_place(DHS, shadow.de_lead, HT);
    wire [CW-1:0] de_end_pos   = seo_place(DHE, shadow.de_trail, HT);

    // [R05] Vertical edges only at a line start, whole lines apart.
    wire vs_set = line_start && (vcnt == vs_start_pos);
    wire vs_clr = line_start && (vcnt == vs_end_pos);
    wire vb_set = line_start && (vcnt == vb_start_pos);
    wire vb_clr = line_start && (vcnt == vb_end_pos);

    seo_edge_flag u_hs (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .en      (pix_en),
        .set     (line_start),
        .clr     (hcnt == hs_end_pos),
        .flag    (hs_flag)
    );

    seo_edge_flag u_vs (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .en      (pix_en),
        .set     (vs_set),
        .clr     (vs_clr),
        .flag    (vs_flag)
    );

    seo_edge_flag u_vb (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .en      (pix_en),
        .set     (vb_set),
        .clr     (vb_clr),
        .flag    (vb_flag)
    );

    seo_edge_flag u_de (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .en      (pix_en),
        .set     (hcnt == de_start_pos),
        .clr     (hcnt == de_end_pos),
        .flag    (hde_flag)
    );

    // Outputs leave from one register stage; field changes one pixel ahead of the flag outputs.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sync_out <= '0;
        end else begin
            sync_out.hsync <= hs_flag && run;
            sync_out.vsync <= vs_flag && run;
            sync_out.de    <= hde_flag && !vb_flag && run;
            sync_out.field <= field;
        end
    end

endmodule

/* logic/seo_timing_note_unused.sv */
// Holds no logic; the block lives in seo_timing.sv and seo_edge_flag.sv.

/* tb/seo_timing_asserts.sv */
// Bus and sync output checks bound to the sync edge offset block.
`timescale 1ns/100ps
`include "seo_params.svh"

module seo_timing_asserts #(
    parameter int H_TOTAL = `SEO_H_TOTAL
) (
    input wire logic               sys_clk,
    input wire logic               nrst,
    input wire logic               wb_cyc_i,
    input wire logic               wb_stb_i,
    input wire logic               wb_we_i,
    input wire logic [9:0]         wb_adr_i,
    input wire logic [3:0]         wb_sel_i,
    input wire logic [31:0]        wb_dat_i,
    input wire logic [31:0]        wb_dat_o,
    input wire logic               wb_ack_o,
    input wire seo_pkg::seo_sync_t sync_out
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    logic        hs_q;
    logic        hseen;
    logic [15:0] hper;
    logic [7:0]  shadow;
    wire         hs_rise;
    wire         lo_hit;

    assign hs_rise = sync_out.hsync & ~hs_q;
    assign lo_hit  = wb_ack_o && (wb_adr_i[9:2] == `SEO_IDX_HS_LO);

    // Counts cycles between line starts and mirrors one offset register.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            hs_q   <= 1'b0;
            hseen  <= 1'b0;
            hper   <= 16'h0000;
            shadow <= 8'h00;
        end else begin
            hs_q  <= sync_out.hsync;
            hseen <= hseen | hs_rise;
            hper  <= hs_rise ? 16'h0000 : hper + 16'h0001;
            if (lo_hit && wb_we_i && wb_sel_i[0])
                shadow <= wb_dat_i[7:0];
        end
    end

    ack_single_a:
        assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_answer_a:
        assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    ack_cause_a:
        assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    dat_idle_a:
        assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data not zero outside ack");
    dat_upper_a:
        assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
        else $error("upper read data bits set");
    hs_readback_a:
        assert property (lo_hit && !wb_we_i |-> wb_dat_o[7:0] == shadow)
        else $error("offset register read back wrong");
    line_period_a:
        assert property (hs_rise && hseen |-> hper == H_TOTAL - 1)
        else $error("line start moved");
    vs_on_line_a:
        assert property ($changed(sync_out.vsync) |-> $rose(sync_out.hsync))
        else $error("vsync edge off a line start");
endmodule

bind seo_timing seo_timing_asserts #(.H_TOTAL(H_TOTAL)) u_asserts (
    .sys_clk (sys_clk),  .nrst     (nrst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i (wb_stb_i),
    .wb_we_i (wb_we_i),  .wb_adr_i (wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i (wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o (wb_ack_o),
    .sync_out(sync_out)
);

/* tb/seo_video_sink.sv */
// Downstream video sink that measures sync and data enable timing.
`timescale 1ns/100ps

module seo_video_sink (
    input wire logic               sys_clk,
    input wire seo_pkg::seo_sync_t sync_out,
    output int                     hs_width,
    output int                     vs_width,
    output int                     de_width,
    output int                     de_lines,
    output logic                   vs_field,
    output int                     frames
);
    seo_pkg::seo_sync_t p;
    int                 hc;
    int                 vc;
    int                 dc;
    int                 dl;

    // Widths are taken at falling edges, line counts at each vsync rise.
    always @(posedge sys_clk) begin
        p  <= sync_out;
        hc <= sync_out.hsync ? hc + 1 : 0;
        vc <= sync_out.vsync ? vc + 1 : 0;
        dc <= sync_out.de ? dc + 1 : 0;
        if (p.hsync && !sync_out.hsync)
            hs_width <= hc;
        if (p.vsync && !sync_out.vsync) begin
            vs_width <= vc;
            vs_field <= p.field;
        end
        if (p.de && !sync_out.de)
            de_width <= dc;
        if (sync_out.de && !p.de)
            dl <= dl + 1;
        if (sync_out.vsync && !p.vsync) begin
            de_lines <= dl;
            dl       <= 0;
            frames   <= frames + 1;
        end
    end
endmodule

/* tb/seo_timing_tb_top.sv */
// Self-checking bench for the sync edge offset block.
`timescale 1ns/100ps

module seo_timing_tb_top;
    localparam int HT   = 80;
    localparam int HSW  = 8;
    localparam int DHS  = 20;
    localparam int DHE  = 70;
    localparam int VT   = 40;
    localparam int VSS  = 10;
    localparam int VSE  = 14;
    localparam int VBS  = 10;
    localparam int VBE  = 20;
    localparam int PDIV = 1;
    logic               sys_clk;
    logic               nrst;
    logic               cyc;
    logic               stb;
    logic               we;
    logic [9:0]         adr;
    logic [3:0]         sel;
    logic [31:0]        wdat;
    logic [31:0]        rdat;
    logic               ack;
    seo_pkg::seo_sync_t sync_out;
    int                 hs_w;
    int                 vs_w;
    int                 de_w;
    int                 de_n;
    logic               vs_f;
    int                 frames;
    int                 mismatches;
    int                 n_compared;

    seo_timing #(
        .H_TOTAL(HT),  .HS_WIDTH(HSW), .DE_BEGIN(DHS), .DE_STOP(DHE),
        .V_TOTAL(VT),  .VS_START(VSS), .VS_END(VSE),   .VB_START(VBS),
        .VB_END(VBE),  .PIX_DIV(PDIV)
    ) u_dut (
        .sys_clk (sys_clk), .nrst    (nrst),  .wb_cyc_i(cyc),
        .wb_stb_i(stb),     .wb_we_i (we),    .wb_adr_i(adr),
        .wb_sel_i(sel),     .wb_dat_i(wdat),  .wb_dat_o(rdat),
        .wb_ack_o(ack),     .sync_out(sync_out)
    );

    seo_video_sink u_sink (
        .sys_clk (sys_clk), .sync_out(sync_out), .hs_width(hs_w),
        .vs_width(vs_w),    .de_width(de_w),     .de_lines(de_n),
        .vs_field(vs_f),    .frames  (frames)
    );

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] idx,
                       input logic [7:0] d, output logic [31:0] q);
        int n;
        n = 0;
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= {idx, 2'b00};
        wdat <= {24'h00_0000, d};
        do begin
            @(posedge sys_clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            mismatches++;
            wrap_up();
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
    endtask

    task automatic frames_wait(input int k);
        int f;
        f = frames;
        wait (frames >= f + k);
        @(posedge sys_clk);
    endtask

    task automatic t_regs;
        logic [7:0]  idx [9] = '{8'h69, 8'h7C, 8'h7D, 8'h7F, 8'h89,
                                 8'h8B, 8'h8C, 8'h8D, 8'h8E};
        logic [7:0]  msk [9] = '{8'h04, 8'h03, 8'hFF, 8'hFF, 8'hFF,
                                 8'h0F, 8'hFF, 8'hFF, 8'hFF};
        logic [31:0] q;
        foreach (idx[i]) begin
            bus(1'b0, idx[i], 8'h00, q);
            check("reset value", q, 32'h0000_0000);
            wr(idx[i], 8'hFF);
            bus(1'b0, idx[i], 8'h00, q);
            check("read back", q, {24'h00_0000, msk[i]});
            wr(idx[i], 8'h00);
        end
        wr(8'h50, 8'hFF);
        bus(1'b0, 8'h50, 8'h00, q);
        check("unmapped", q, 32'h0000_0000);
        sel <= 4'hE;
        wr(8'h7D, 8'h5A);
        sel <= 4'hF;
        bus(1'b0, 8'h7D, 8'h00, q);
        check("masked write", q, 32'h0000_0000);
    endtask

    task automatic t_nominal;
        wr(8'hA0, 8'h01);
        frames_wait(2);
        check("hsync width", hs_w, 8);
        check("vsync width", vs_w, 4 * HT);
        check("enable width", de_w, 50);
        check("active lines", de_n, 30);
    endtask

    task automatic t_hs;
        wr(8'h7D, 8'h05);
        repeat (HT) @(posedge sys_clk);
        check("hsync held", hs_w, 8);
        frames_wait(2);
        check("hsync delayed", hs_w, 13);
        wr(8'h7C, 8'h03);
        wr(8'h7D, 8'hFD);
        frames_wait(2);
        check("hsync advanced", hs_w, 5);
    endtask

    task automatic t_vs;
        wr(8'h7F, 8'hF2);
        frames_wait(2);
        check("vsync lines", vs_w, 7 * HT);
        wr(8'h7F, 8'h87);
        frames_wait(2);
        check("vsync lines", vs_w, 19 * HT);
        wr(8'h7F, 8'h00);
    endtask

    task automatic t_de;
        wr(8'h8B, 8'h0C);
        wr(8'h8C, 8'h02);
        wr(8'h8D, 8'hFF);
        frames_wait(2);
        check("enable width", de_w, 53);
        wr(8'h8B, 8'h03);
        wr(8'h8C, 8'hFD);
        wr(8'h8D, 8'h05);
        frames_wait(2);
        check("enable width", de_w, 42);
    endtask

    task automatic t_vb;
        wr(8'h8E, 8'h2F);
        frames_wait(2);
        check("active lines", de_n, 33);
        wr(8'h8E, 8'h87);
        frames_wait(2);
        check("active lines", de_n, 15);
    endtask

    task automatic t_even;
        wr(8'h89, 8'hF3);
        wr(8'hA0, 8'h03);
        frames_wait(2);
        repeat (2) begin
            frames_wait(1);
            check("field vsync", vs_w, (vs_f === 1'b1 ? 8 : 4) * HT);
        end
    endtask

    // Progressive 525 mode: blanking from line 1, then from line 523,
    // which lies beyond this short frame, so no line is blanked.
    task automatic t_525p;
        wr(8'h8E, 8'h00);
        wr(8'hA0, 8'h05);
        frames_wait(2);
        check("line 1 blanking", de_n, VT - VBE);
        wr(8'h69, 8'h04);
        frames_wait(2);
        check("line 523 blanking", de_n, VT);
    endtask

    task automatic wrap_up;
        if (mismatches == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        #380000;
        mismatches++;
        wrap_up();
    end

    initial begin
        nrst = 1'b0;
        cyc  = 1'b0;
        stb  = 1'b0;
        we   = 1'b0;
        adr  = 10'h000;
        sel  = 4'hF;
        wdat = 32'h0000_0000;
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        t_regs();
        t_nominal();
        t_hs();
        t_vs();
        t_de();
        t_vb();
        t_even();
        t_525p();
        wrap_up();
    end
endmodule
